// *** logic/mpc_carrier_core.sv ***
// module: carrier counter with step prescaler and double-buffered period
`timescale 1ns/1ps
`default_nettype none
module mpc_carrier_core
   import mpc_pkg::*;
(
   // clock and reset
   input wire logic   hclk,
   input wire logic   hresetn,
   // settings in, counter state out
   mpc_carrier_if.core cif
);
   mpc_dir_state_t st_q, st_d;
   logic [15:0]    cnt_q, cnt_d;
   logic [15:0]    act_q, act_d;
   logic [2:0]     pre_q, pre_d;
   logic           dir_q, dir_d;
   logic [3:0]     div;
   logic           step;
   logic           reload;

   // ==========================================
   // next state of prescaler, count, direction and active period
   always_comb
   begin
      div = cif.shape ? 4'(TRI_DIV) : 4'(SAW_DIV);
      if (cif.ext)
         div = 4'(32'(div) * EXT_FACTOR);
      // >= so a shorter divisor chosen mid-step cannot stall the count
      step   = cif.enable && ({1'b0, pre_q} >= div - 4'h1);
      reload = step && (cnt_q == act_q ||
               (cif.half_mode && cif.shape && cnt_q == CNT_LOW));
      st_d   = st_q;
      cnt_d  = cnt_q;
      act_d  = act_q;
      pre_d  = step ? 3'h0 : pre_q + 3'h1;
      if (!cif.enable)
      begin
         st_d  = MPC_IDLE;
         pre_d = 3'h0;
         act_d = cif.period_buf;
         cnt_d = cif.shape ? cif.period_buf : CNT_REST;
      end
      else if (step)
      begin
         if (!cif.shape)
         begin
            // sawtooth: 1 .. period, then restart
            st_d  = MPC_UP;
            cnt_d = (cnt_q >= act_q) ? CNT_LOW : cnt_q + 16'h0001;
         end
         else
         begin
            case (st_q)
               MPC_DOWN:
                  if (cnt_q <= CNT_LOW)
                  begin
                     st_d  = MPC_UP;
                     cnt_d = cnt_q + 16'h0001;
                  end
                  else
                     cnt_d = cnt_q - 16'h0001;
               default:
                  if (cnt_q >= act_q)
                  begin
                     st_d  = MPC_DOWN;
                     cnt_d = cnt_q - 16'h0001;
                  end
                  else
                  begin
                     st_d  = MPC_UP;
                     cnt_d = cnt_q + 16'h0001;
                  end
            endcase
         end
         if (reload)
            act_d = cif.period_buf;
      end
      // a down state left over from triangle must not show once sawtooth is chosen
      dir_d = cif.shape && (st_d == MPC_DOWN);
   end

   // ==========================================
   // state registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_q  <= MPC_IDLE;
         cnt_q <= 16'h0000;
         act_q <= PERIOD_RST;
         pre_q <= 3'h0;
         dir_q <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         act_q <= act_d;
         pre_q <= pre_d;
         dir_q <= dir_d;
      end
   end

   assign cif.count      = cnt_q;
   assign cif.dir        = dir_q;
   assign cif.period_act = act_q;

   // ==========================================
   // checks
   a_dir_saw_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      !cif.shape && $past(!cif.shape) |-> !dir_q) else $error("direction set on sawtooth");
   a_saw_full_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      cif.enable && !cif.shape && !cif.ext && $past(cif.enable && !cif.shape && !cif.ext)
      |-> step) else $error("sawtooth step missed");
   a_ext_slow_rate: assert property (@(posedge hclk) disable iff (!hresetn)
      step && cif.ext && !cif.shape ##1 (cif.enable && cif.ext && !cif.shape)[*3]
      |-> !step && $past(!step) && $past(!step, 2)) else $error("extended step too fast");
   a_saw_wrap_one: assert property (@(posedge hclk) disable iff (!hresetn)
      step && !cif.shape && cnt_q >= act_q |=> cnt_q == CNT_LOW) else $error("sawtooth did not wrap");
   a_period_held: assert property (@(posedge hclk) disable iff (!hresetn)
      cif.enable && !reload |=> act_q == $past(act_q)) else $error("active period moved");
endmodule // mpc_carrier_core
`default_nettype wire

// *** logic/mpc_carrier_if.sv ***
// interface: settings from the register file and state of the carrier counter
`timescale 1ns/1ps
`default_nettype none
interface mpc_carrier_if;
   logic        enable;
   logic        shape;
   logic        ext;
   logic        half_mode;
   logic [15:0] period_buf;
   logic [15:0] count;
   logic        dir;
   logic [15:0] period_act;
   modport regs (output enable, shape, ext, half_mode, period_buf, input count, dir, period_act);
   modport core (input enable, shape, ext, half_mode, period_buf, output count, dir, period_act);
endinterface
`default_nettype wire

// *** logic/mpc_pkg.sv ***
// package: register map, field layout and timing of the motor pwm carrier counter
package mpc_pkg;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_COUNT  = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0c;
   // ==========================================
   // control field positions
   localparam int CTL_SHAPE_BIT  = 0;
   localparam int CTL_INTPRD_LSB = 1;
   localparam int CTL_EXT_BIT    = 6;
   localparam int CTL_EN_BIT     = 8;
   localparam int STA_DIR_BIT    = 0;
   localparam logic [1:0] INTPRD_HALF = 2'h0;
   // ==========================================
   // reset and rest values
   localparam logic [15:0] PERIOD_RST = 16'h0000;
   localparam logic [15:0] CNT_REST   = 16'h0001;
   localparam logic [15:0] CNT_LOW    = 16'h0001;
   // ==========================================
   // step timing, expressed at the reference system clock
   localparam int SYS_REF_MHZ  = 80;
   localparam int STEP_SAW_PS  = 12500;
   localparam int STEP_TRI_PS  = 25000;
   localparam int EXT_FACTOR   = 4;
   localparam int SAW_DIV      = STEP_SAW_PS * SYS_REF_MHZ / 1000000;
   localparam int TRI_DIV      = STEP_TRI_PS * SYS_REF_MHZ / 1000000;
   // ==========================================
   // counter direction state, gray along idle -> up -> down
   typedef enum logic [1:0]
   {
      MPC_IDLE = 2'b00,
      MPC_UP   = 2'b01,
      MPC_DOWN = 2'b11
   } mpc_dir_state_t;
endpackage

// *** logic/mpc_top.sv ***
// module: ahb-lite register file and carrier counter of the motor pwm unit
//
// Overview of operation
// - Bit 0 of the status register reads 0 while the counter counts up and 1 while it counts down.
// - With the sawtooth carrier the direction bit always reads 0.
// - A read-only 16-bit count register shows the live count and ignores writes.
// - With normal period the count steps every sawtooth clock or every second clock for triangle.
// - With period extension set the counter steps four times more slowly.
// - While disabled with sawtooth selected the count holds 1.
// - While disabled with triangle selected the count holds the programmed period.
// - A 16-bit read-write period register sets the carrier period, programmed no lower than 0x010.
// - The period is double-buffered and the active copy changes only at a reload or while the counter is disabled.
// - The active period reloads when the count equals it, and in half-period mode with triangle also at count 1.
// - The shape bit selects sawtooth at 0 and triangle at 1.
// - The extension bit selects normal period at 0 and four-times period at 1.
// - The two-bit interrupt-period field selects half, one, two or four periods, half for triangle only.
`timescale 1ns/1ps
`default_nettype none
module mpc_top
   import mpc_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // carrier state to compare, output and trigger logic
   output logic      [15:0] carrier_count,
   output logic             count_direction_flag,
   output logic      [15:0] active_period
);

   // ==========================================
   // register state
   logic        en_q, en_d;
   logic        shape_q, shape_d;
   logic        ext_q, ext_d;
   logic [1:0]  intprd_q, intprd_d;
   logic [15:0] prd_q, prd_d;
   logic        wr_pend_q, wr_pend_d;
   logic [7:0]  wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic        addr_phase;

   mpc_carrier_if cif ();

   // ==========================================
   // read decode, zero above each register's width
   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         OFS_CTRL:
         begin
            w[CTL_SHAPE_BIT]                    = shape_q;
            w[CTL_INTPRD_LSB +: 2]              = intprd_q;
            w[CTL_EXT_BIT]                      = ext_q;
            w[CTL_EN_BIT]                       = en_q;
         end
         OFS_STATUS: w[STA_DIR_BIT] = cif.dir;
         OFS_COUNT:  w[15:0] = cif.count;
         OFS_PERIOD: w[15:0] = prd_q;
         default:    w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ==========================================
   // bus next state: zero-wait slave, read data fetched in the address phase
   always_comb
   begin
      addr_phase = hsel && hready && htrans[1];
      wr_pend_d  = addr_phase && hwrite;
      wr_addr_d  = addr_phase ? {haddr[7:2], 2'b00} : wr_addr_q;
      rdata_d    = (addr_phase && !hwrite) ? read_word({haddr[7:2], 2'b00}) : rdata_q;
      en_d       = en_q;
      shape_d    = shape_q;
      ext_d      = ext_q;
      intprd_d   = intprd_q;
      prd_d      = prd_q;
      if (wr_pend_q)
      begin
         case (wr_addr_q)
            OFS_CTRL:
            begin
               shape_d  = hwdata[CTL_SHAPE_BIT];
               intprd_d = hwdata[CTL_INTPRD_LSB +: 2];
               ext_d    = hwdata[CTL_EXT_BIT];
               en_d     = hwdata[CTL_EN_BIT];
            end
            // only the low half is kept; a byte write would leave a torn value
            OFS_PERIOD: prd_d = hwdata[15:0];
            // status and count take no write
            default: prd_d = prd_q;
         endcase
      end
   end

   // ==========================================
   // bus and register flip-flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en_q      <= 1'b0;
         shape_q   <= 1'b0;
         ext_q     <= 1'b0;
         intprd_q  <= 2'h0;
         prd_q     <= PERIOD_RST;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q   <= 32'h0000_0000;
      end
      else
      begin
         en_q      <= en_d;
         shape_q   <= shape_d;
         ext_q     <= ext_d;
         intprd_q  <= intprd_d;
         prd_q     <= prd_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q   <= rdata_d;
      end
   end

   // ==========================================
   // handshake outputs: always ready, always okay, held in flops
   logic ready_q;
   logic resp_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end
      else
      begin
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = ready_q;
   assign hresp     = resp_q;

   // ==========================================
   // settings to the counter; half mode only means something for triangle
   assign cif.enable     = en_q;
   assign cif.shape      = shape_q;
   assign cif.ext        = ext_q;
   assign cif.half_mode  = (intprd_q == INTPRD_HALF);
   assign cif.period_buf = prd_q;

   mpc_carrier_core u_core
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cif     (cif.core)
   );

   assign carrier_count        = cif.count;
   assign count_direction_flag = cif.dir;
   assign active_period        = cif.period_act;

   // ==========================================
   // checks
   a_count_read_live: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[7:0] == OFS_COUNT
      |=> hrdata == {16'h0000, $past(cif.count)}) else $error("count readback wrong");
   a_status_dir_bit: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[7:0] == OFS_STATUS
      |=> hrdata == {31'h0, $past(cif.dir)}) else $error("status readback wrong");
   a_period_write_kept: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == OFS_PERIOD
      |=> prd_q == $past(hwdata[15:0])) else $error("period write lost");
   a_count_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_q && wr_addr_q == OFS_COUNT |=> $stable(prd_q) && $stable(en_q))
      else $error("count write had effect");
   a_idle_saw_one: assert property (@(posedge hclk) disable iff (!hresetn)
      !en_q && !shape_q && $past(!en_q && !shape_q) && $past(hresetn)
      |-> carrier_count == CNT_REST) else $error("idle sawtooth count not 1");
   a_idle_tri_prd: assert property (@(posedge hclk) disable iff (!hresetn)
      !en_q && shape_q && $past(!en_q && shape_q)
      |-> carrier_count == $past(prd_q)) else $error("idle triangle count not period");
   a_reload_point: assert property (@(posedge hclk) disable iff (!hresetn)
      en_q && $past(en_q) && active_period != $past(active_period)
      |-> $past(carrier_count) == $past(active_period)
          || ($past(cif.half_mode && shape_q) && $past(carrier_count) == CNT_LOW))
      else $error("period reloaded off boundary");
   a_ready_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase |=> hreadyout && !hresp) else $error("slave stalled or errored");
endmodule // mpc_top
`default_nettype wire

// *** sim/tb_mpc_top.sv ***
// testbench: bus and carrier checks of the motor pwm carrier counter
`timescale 1ns/1ps
`default_nettype none
module tb_mpc_top
   import mpc_pkg::*;
;
   // ==========================================
   // signals
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [15:0] carrier_count;
   logic        count_direction_flag;
   logic [15:0] active_period;
   int          n_fail = 0;
   int          n_tests = 0;

   // single slave, so its ready is the bus ready
   assign hready = hreadyout;

   mpc_top DUT (
      .hclk                 (hclk),
      .hresetn              (hresetn),
      .hsel                 (hsel),
      .haddr                (haddr),
      .htrans               (htrans),
      .hwrite               (hwrite),
      .hsize                (hsize),
      .hwdata               (hwdata),
      .hready               (hready),
      .hrdata               (hrdata),
      .hreadyout            (hreadyout),
      .hresp                (hresp),
      .carrier_count        (carrier_count),
      .count_direction_flag (count_direction_flag),
      .active_period        (active_period)
   );

   // ==========================================
   // helpers
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // sample one nanosecond past the edge so the design's updates have landed
   task automatic tick;
      @(posedge hclk);
      #1;
   endtask

   function automatic logic [31:0] ctl(input logic sh, input logic [1:0] ip, input logic ex, input logic en);
      ctl = (32'(sh) << CTL_SHAPE_BIT) | (32'(ip) << CTL_INTPRD_LSB) | (32'(ex) << CTL_EXT_BIT)
            | (32'(en) << CTL_EN_BIT);
   endfunction

   // single word transfer; trailing idle so a following read sees the write
   task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      q = hrdata;
      if (wr)
         @(posedge hclk);
      // step off the edge so later looks at the outputs see settled values
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_xfer(a, 1'b1, d, q);
   endtask

   // poll each cycle, so a hit is the first cycle the value shows
   task automatic wait_cnt(input logic [15:0] v, input int lim);
      int n;
      n = 0;
      while (carrier_count !== v && n < lim)
      begin
         tick();
         n++;
      end
      chk(32'(carrier_count), 32'(v));
   endtask

   // follow the carrier step by step, from a known point of the ramp
   task automatic walk(input logic [15:0] p, input int sp, input logic tr, input int steps);
      logic [15:0] cur;
      logic        dn;
      cur = tr ? p - 16'h2 : 16'h3;
      dn  = tr;
      wait_cnt(cur, 100);
      for (int s = 0; s < steps; s++)
      begin
         repeat (sp - 1)
         begin
            tick();
            chk(32'(carrier_count), 32'(cur));
         end
         tick();
         if (dn && cur == 16'h1)
            dn = 1'b0;
         if (!dn && cur == p)
            dn = tr;
         cur = dn ? cur - 16'h1 : cur + 16'h1;
         if (cur > p)
            cur = 16'h1;
         chk(32'(carrier_count), 32'(cur));
         if (cur != 16'h1 && cur != p)
            chk(32'(count_direction_flag), 32'(dn));
      end
   endtask

   // ==========================================
   // scenarios
   task automatic t_regs;
      logic [31:0] d;
      ahb_xfer(OFS_STATUS, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      ahb_xfer(OFS_COUNT, 1'b0, 32'h0, d);
      chk(d, 32'h1);
      ahb_xfer(OFS_PERIOD, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      chk(32'(hresp), 32'h0);
      wr(OFS_PERIOD, 32'hffff_0010);
      wr(OFS_COUNT, 32'h0000_1234);
      wr(OFS_STATUS, 32'hffff_ffff);
      wr(8'h10, 32'h5a5a_5a5a);
      ahb_xfer(OFS_PERIOD, 1'b0, 32'h0, d);
      chk(d, 32'h10);
      ahb_xfer(OFS_COUNT, 1'b0, 32'h0, d);
      chk(d, 32'h1);
      ahb_xfer(OFS_STATUS, 1'b0, 32'h0, d);
      chk(d, 32'h0);
      ahb_xfer(8'h10, 1'b0, 32'h0, d);
      chk(d, 32'h0);
   endtask

   task automatic t_saw_reload;
      wr(OFS_CTRL, ctl(1'b0, 2'h1, 1'b0, 1'b1));
      walk(16'h10, 1, 1'b0, 40);
      wait_cnt(16'h2, 20);
      wr(OFS_PERIOD, 32'h20);
      chk(32'(active_period), 32'h10);
      wait_cnt(16'h1, 16);
      chk(32'(active_period), 32'h20);
      wait_cnt(16'h11, 20);
   endtask

   task automatic t_tri_ext;
      logic [31:0] d;
      wr(OFS_CTRL, ctl(1'b1, 2'h1, 1'b0, 1'b0));
      ahb_xfer(OFS_COUNT, 1'b0, 32'h0, d);
      chk(d, 32'h20);
      wr(OFS_CTRL, ctl(1'b1, 2'h3, 1'b0, 1'b1));
      walk(16'h20, 2, 1'b1, 80);
      wr(OFS_CTRL, ctl(1'b0, 2'h2, 1'b1, 1'b0));
      wr(OFS_PERIOD, 32'h10);
      chk(32'(carrier_count), 32'h1);
      wr(OFS_CTRL, ctl(1'b0, 2'h2, 1'b1, 1'b1));
      walk(16'h10, 4, 1'b0, 20);
   endtask

   // half-period mode reloads at count 1, long before the top of the ramp
   task automatic t_half;
      logic [31:0] d;
      wr(OFS_CTRL, ctl(1'b1, 2'h0, 1'b0, 1'b0));
      wr(OFS_PERIOD, 32'h20);
      wr(OFS_CTRL, ctl(1'b1, 2'h0, 1'b0, 1'b1));
      wait_cnt(16'h1e, 20);
      ahb_xfer(OFS_STATUS, 1'b0, 32'h0, d);
      chk(d, 32'h1);
      wr(OFS_PERIOD, 32'h18);
      chk(32'(active_period), 32'h20);
      wait_cnt(16'h1, 80);
      wait_cnt(16'h2, 10);
      chk(32'(active_period), 32'h18);
   endtask

   // ==========================================
   // clock, watchdog and main sequence
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // whole run is well under 2000 cycles
   initial
   begin
      #(40 * 20000);
      n_fail++;
      close_out();
   end

   initial
   begin
      hresetn = 1'b0;
      hsel    = 1'b1;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_saw_reload();
      t_tri_ext();
      t_half();
      close_out();
   end
endmodule // tb_mpc_top
`default_nettype wire
